// File: common/psf_consts.vh
`ifndef PSF_CONSTS_VH
`define PSF_CONSTS_VH

// register word offsets inside one channel window (byte address bits 4:2)
`define PSF_REG_CTRL 3'h0
`define PSF_REG_MAT0 3'h1
`define PSF_REG_MAT1 3'h2
`define PSF_REG_SPIKE 3'h3
`define PSF_REG_STAT 3'h4
`define PSF_REG_OUT0 3'h5
`define PSF_REG_OUT1 3'h6
// byte address bit that picks channel 1, and bits that must be zero
`define PSF_ADR_CH 5
`define PSF_ADR_HI 7:6

// control register fields
`define PSF_F_THR 6:0
`define PSF_F_MOD 14:8
`define PSF_F_TWO 16
`define PSF_F_SEL 18:17
`define PSF_F_REFR 19
`define PSF_F_SPIKE 20
`define PSF_F_MATMODE 21
// material fields
`define PSF_F_LO 15:0
`define PSF_F_HI 31:16
// spike register fields
`define PSF_F_DEPTH 3:0
`define PSF_F_MAXC 14:8
`define PSF_F_TOL 31:16

// reset values
`define PSF_RST_THR 7'h02
`define PSF_RST_MOD 7'h32
`define PSF_RST_INDEX 16'h1000
`define PSF_RST_ABBE 16'h0000
`define PSF_RST_DEPTH 4'h1
`define PSF_RST_MAXC 7'h00
`define PSF_RST_TOL 16'h0000

// selection codes
`define PSF_SEL_FIRST 2'h0
`define PSF_SEL_HIGH 2'h1
`define PSF_SEL_LAST 2'h2

// limits and scales
`define PSF_PCT_FULL 7'h64
`define PSF_MAX_PEAKS 3'h6
`define PSF_DEPTH_MAX 4'hA
`define PSF_MAXC_MAX 7'h64
`define PSF_INDEX_FRAC 12

`endif

// File: design/psf_spike.v
`timescale 1ns/1ps
`default_nettype none
`include "psf_consts.vh"

module psf_spike #(
	parameter W = 16,
	parameter DEPTH_MAX = 10
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// settings
	input wire en_i,
	input wire [3:0] depth_i,
	input wire [W-1:0] tol_i,
	input wire [6:0] max_corr_i,
	// value stream
	input wire in_valid_i,
	input wire [W-1:0] in_data_i,
	output reg out_valid_o,
	output reg [W-1:0] out_data_o,
	output reg replaced_o
);

	reg [W-1:0] hist [0:DEPTH_MAX-1];
	reg [3:0] fill;
	reg [6:0] run;
	reg [W+3:0] sum;
	integer i;

	// reference is the sum of the newest depth entries; compared scaled, no divide
	always @*
	begin
		sum = {(W+4){1'b0}};
		for (i = 0; i < DEPTH_MAX; i = i + 1)
			if (i < depth_i)
				sum = sum + {4'h0, hist[i]}; // RULE13
	end

	wire [W+3:0] scaled = {4'h0, in_data_i} * {{W{1'b0}}, depth_i};
	wire [W+3:0] band = {4'h0, tol_i} * {{W{1'b0}}, depth_i};
	wire [W+3:0] dev = (scaled > sum) ? scaled - sum : sum - scaled;
	wire primed = (fill >= depth_i); // RULE20
	wire spike = en_i && primed && (dev > band) && (run < max_corr_i); // RULE14 RULE15

	genvar k;
	generate
		for (k = 0; k < DEPTH_MAX; k = k + 1)
		begin : g_hist
			wire [W-1:0] next_hist;
			// head takes the filtered output, the rest shift; no index below zero
			if (k == 0)
			begin : g_head
				assign next_hist = spike ? out_data_o : in_data_i;
			end
			else
			begin : g_tail
				assign next_hist = hist[k-1];
			end
			always @(posedge clk_i)
			begin
				if (rst_i)
					hist[k] <= {W{1'b0}};
				else if (in_valid_i)
					hist[k] <= next_hist;
			end
		end
	endgenerate

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fill <= 4'h0;
			run <= 7'h00;
			out_valid_o <= 1'b0;
			out_data_o <= {W{1'b0}};
			replaced_o <= 1'b0;
		end
		else
		begin
			out_valid_o <= in_valid_i;
			// replacement flag is a pulse that stands only with the new value
			replaced_o <= in_valid_i && spike;
			if (in_valid_i)
			begin
				if (fill < `PSF_DEPTH_MAX)
					fill <= fill + 4'h1;
				// a run of spikes keeps reusing the last corrected output
				out_data_o <= spike ? out_data_o : in_data_i; // RULE14 RULE16
				run <= spike ? run + 7'h01 : 7'h00; // RULE15
			end
		end
	end

endmodule // psf_spike
`default_nettype wire

// File: design/psf_top.v
// What this block does
// RULE1: each channel keeps its own threshold, modulation, count, material and spike settings
// RULE2: a peak counts only if its dark-corrected intensity reaches the threshold
// RULE3: detection threshold is a percentage, two percent after reset
// RULE4: modulation percentage, fifty after reset, sets dip depth that splits peaks
// RULE5: the modulation test runs for every peak above threshold
// RULE6: at most six peaks per channel, numbered from range start to end
// RULE7: one value: first, highest or last peak by selection
// RULE8: two values: first pair, two highest, or last pair by selection
// RULE9: peak heights for ranking come from the light-corrected signal
// RULE10: refractive correction on by default, can be switched off
// RULE11: with layers, distance from first peak, thickness from first two
// RULE12: material is index plus Abbe number, or three indices
// RULE13: spike reference is the mean of the last evaluation-length readings, ten max
// RULE14: value outside the band around the reference becomes the previous output
// RULE15: consecutive replacements limited to a count of at most one hundred
// RULE16: during spike runs the corrected value is reused
// RULE17: spike correction acts alike on every output distance
// RULE18: spike correction comes before any averaging
// RULE19: order is linearization, refraction, invalid handling, spike correction
// RULE20: spike filter passes values until its history holds evaluation-length entries
`timescale 1ns/1ps
`default_nettype none
`include "psf_consts.vh"

module psf_top #(
	parameter D_W = 12,
	parameter P_W = 16
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// video samples, one lane per channel
	input wire [1:0] vid_valid_i,
	input wire [1:0] vid_start_i,
	input wire [1:0] vid_last_i,
	input wire [2*D_W-1:0] vid_dark_i,
	input wire [2*D_W-1:0] vid_light_i,
	// corrected distances, one lane per channel
	output wire [1:0] dist_valid_o,
	output wire [2*P_W-1:0] dist_a_o,
	output wire [2*P_W-1:0] dist_b_o,
	output wire [1:0] dist_spike_o,
	output reg [1:0] dist_err_o
);

	// per-channel settings
	reg [31:0] cfg_ctrl [0:1]; // RULE1
	reg [31:0] cfg_mat0 [0:1];
	reg [31:0] cfg_mat1 [0:1];
	reg [31:0] cfg_spike [0:1];
	wire [31:0] stat_w [0:1];
	wire [31:0] out0_w [0:1];
	wire [31:0] out1_w [0:1];

	wire ch = wb_adr_i[`PSF_ADR_CH];
	wire [2:0] rsel = wb_adr_i[4:2];
	wire mapped = (wb_adr_i[`PSF_ADR_HI] == 2'h0) && (rsel <= `PSF_REG_OUT1);
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = req && wb_we_i && mapped;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (sel[b])
					merge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	wire [31:0] wmask = merge(cfg_ctrl[ch], wb_dat_i, wb_sel_i);
	wire [31:0] wspk = merge(cfg_spike[ch], wb_dat_i, wb_sel_i);
	wire [3:0] wdep = wspk[`PSF_F_DEPTH];
	wire [6:0] wmax = wspk[`PSF_F_MAXC];

	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1)
		begin : g_cfg
			always @(posedge clk_i)
			begin
				if (rst_i)
				begin
					cfg_ctrl[c] <= 32'h0000_0000;
					cfg_ctrl[c][`PSF_F_THR] <= `PSF_RST_THR; // RULE3
					cfg_ctrl[c][`PSF_F_MOD] <= `PSF_RST_MOD; // RULE4
					cfg_ctrl[c][`PSF_F_REFR] <= 1'b1; // RULE10
					cfg_mat0[c] <= {`PSF_RST_ABBE, `PSF_RST_INDEX};
					cfg_mat1[c] <= {`PSF_RST_INDEX, `PSF_RST_INDEX};
					cfg_spike[c] <= {`PSF_RST_TOL, 1'b0, `PSF_RST_MAXC, 4'h0, `PSF_RST_DEPTH};
				end
				else if (wr && (ch == c))
				begin
					case (rsel)
						`PSF_REG_CTRL: cfg_ctrl[c] <= wmask;
						`PSF_REG_MAT0: cfg_mat0[c] <= merge(cfg_mat0[c], wb_dat_i, wb_sel_i);
						`PSF_REG_MAT1: cfg_mat1[c] <= merge(cfg_mat1[c], wb_dat_i, wb_sel_i);
						`PSF_REG_SPIKE:
						begin
							cfg_spike[c] <= wspk;
							// evaluation length kept in 1..10, run limit at most 100
							cfg_spike[c][`PSF_F_DEPTH] <= (wdep == 4'h0) ? 4'h1 :
								(wdep > `PSF_DEPTH_MAX) ? `PSF_DEPTH_MAX : wdep; // RULE13
							cfg_spike[c][`PSF_F_MAXC] <= (wmax > `PSF_MAXC_MAX) ?
								`PSF_MAXC_MAX : wmax; // RULE15
						end
						default: cfg_ctrl[c] <= cfg_ctrl[c];
					endcase
				end
			end
		end
	endgenerate

	// bus answer one cycle after the request; unmapped reads return zero
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= req;
			wb_dat_o <= 32'h0000_0000;
			if (req && !wb_we_i && mapped)
			begin
				case (rsel)
					`PSF_REG_CTRL: wb_dat_o <= cfg_ctrl[ch];
					`PSF_REG_MAT0: wb_dat_o <= cfg_mat0[ch];
					`PSF_REG_MAT1: wb_dat_o <= cfg_mat1[ch];
					`PSF_REG_SPIKE: wb_dat_o <= cfg_spike[ch];
					`PSF_REG_STAT: wb_dat_o <= stat_w[ch];
					`PSF_REG_OUT0: wb_dat_o <= out0_w[ch];
					`PSF_REG_OUT1: wb_dat_o <= out1_w[ch];
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	generate
		for (c = 0; c < 2; c = c + 1)
		begin : g_ch
			wire [31:0] ctl = cfg_ctrl[c];
			wire [D_W-1:0] dk = vid_dark_i[c*D_W +: D_W];
			wire [D_W-1:0] lt = vid_light_i[c*D_W +: D_W];
			wire vv = vid_valid_i[c];
			wire [6:0] keep = `PSF_PCT_FULL - ctl[`PSF_F_MOD];
			wire [D_W-1:0] full = {D_W{1'b1}};

			reg [P_W-1:0] pk_pos [0:5];
			reg [D_W-1:0] pk_h [0:5];
			reg [2:0] npk;
			reg in_pk;
			reg [P_W-1:0] pos;
			reg [D_W-1:0] cur_max;
			reg [D_W-1:0] cur_h;
			reg [D_W-1:0] valley;
			reg [P_W-1:0] cur_pos;
			reg eval;

			wire [P_W-1:0] here = vid_start_i[c] ? {P_W{1'b0}} : pos;
			wire [2:0] npk_b = vid_start_i[c] ? 3'h0 : npk;
			wire in_b = vid_start_i[c] ? 1'b0 : in_pk;
			wire [D_W+6:0] dk_pct = dk * `PSF_PCT_FULL;
			wire [D_W+6:0] thr_lvl = full * ctl[`PSF_F_THR];
			wire above = (dk_pct >= thr_lvl); // RULE2
			wire [D_W+6:0] val_pct = valley * `PSF_PCT_FULL;
			wire [D_W+6:0] max_keep = cur_max * keep;
			wire [D_W+6:0] dk_keep = dk * keep;
			// split when the dip below both neighbouring maxima is deep enough
			wire split = in_b && above && (dk > valley) &&
				(val_pct <= max_keep) && (val_pct <= dk_keep); // RULE4 RULE5
			wire commit = in_b && (!above || split || vid_last_i[c]);
			wire room = (npk_b < `PSF_MAX_PEAKS); // RULE6

			always @(posedge clk_i)
			begin
				if (rst_i)
				begin
					npk <= 3'h0;
					in_pk <= 1'b0;
					pos <= {P_W{1'b0}};
					cur_max <= {D_W{1'b0}};
					cur_h <= {D_W{1'b0}};
					valley <= {D_W{1'b0}};
					cur_pos <= {P_W{1'b0}};
					eval <= 1'b0;
				end
				else
				begin
					eval <= vv && vid_last_i[c];
					if (vv)
					begin
						// linearization taken as identity: sample index is the distance
						pos <= here + {{(P_W-1){1'b0}}, 1'b1}; // RULE19
						npk <= npk_b;
						in_pk <= in_b;
						if (commit && room)
						begin
							pk_pos[npk_b] <= cur_pos; // RULE6
							pk_h[npk_b] <= cur_h;
							npk <= npk_b + 3'h1;
						end
						if (vid_last_i[c])
							in_pk <= 1'b0;
						else if (split || (!in_b && above))
						begin
							in_pk <= 1'b1;
							cur_max <= dk;
							cur_h <= lt; // RULE9
							cur_pos <= here;
							valley <= dk;
						end
						else if (in_b && !above)
							in_pk <= 1'b0;
						else if (in_b && dk > cur_max)
						begin
							cur_max <= dk;
							cur_h <= lt; // RULE9
							cur_pos <= here;
							valley <= dk;
						end
						else if (in_b && dk < valley)
							valley <= dk;
					end
				end
			end

			// ranking of the stored peaks by light-corrected height
			reg [2:0] hi1;
			reg [2:0] hi2;
			integer j;
			always @*
			begin
				hi1 = 3'h0;
				hi2 = 3'h1;
				if (pk_h[1] > pk_h[0] && npk > 3'h1)
				begin
					hi1 = 3'h1;
					hi2 = 3'h0;
				end
				for (j = 2; j < 6; j = j + 1)
				begin
					if (j < npk)
					begin
						if (pk_h[j] > pk_h[hi1])
						begin
							hi2 = hi1;
							hi1 = j[2:0];
						end
						else if (pk_h[j] > pk_h[hi2])
							hi2 = j[2:0];
					end
				end
			end

			wire two = ctl[`PSF_F_TWO];
			wire [1:0] sel = ctl[`PSF_F_SEL];
			wire [2:0] lst = npk - 3'h1;
			wire [2:0] prl = npk - 3'h2;
			wire [2:0] ia = (sel == `PSF_SEL_HIGH) ? hi1 :
				(sel == `PSF_SEL_LAST) ? (two ? prl : lst) : 3'h0; // RULE7 RULE8
			wire [2:0] ib = (sel == `PSF_SEL_HIGH) ? hi2 :
				(sel == `PSF_SEL_LAST) ? lst : 3'h1; // RULE8
			wire ok = (npk != 3'h0) && (!two || npk > 3'h1);

			// index in use: nd with Abbe number, or the middle of three indices
			wire [15:0] nidx = ctl[`PSF_F_MATMODE] ? cfg_mat1[c][`PSF_F_LO] :
				cfg_mat0[c][`PSF_F_LO]; // RULE12
			// depth behind the first surface scales by the index
			wire [P_W-1:0] p0 = pk_pos[0]; // RULE11
			wire [P_W-1:0] ra = pk_pos[ia];
			wire [P_W-1:0] rb = pk_pos[ib];
			wire [P_W+15:0] pa = (ra - p0) * nidx;
			wire [P_W+15:0] pb = (rb - p0) * nidx;
			wire [P_W-1:0] ca = ctl[`PSF_F_REFR] ? p0 + pa[`PSF_INDEX_FRAC +: P_W] : ra; // RULE10
			wire [P_W-1:0] cb = ctl[`PSF_F_REFR] ? p0 + pb[`PSF_INDEX_FRAC +: P_W] : rb; // RULE10

			reg cv;
			reg [P_W-1:0] da;
			reg [P_W-1:0] db;
			reg last_ok;
			always @(posedge clk_i)
			begin
				if (rst_i)
				begin
					cv <= 1'b0;
					da <= {P_W{1'b0}};
					db <= {P_W{1'b0}};
					last_ok <= 1'b0;
					dist_err_o[c] <= 1'b0;
				end
				else
				begin
					// invalid frames hold the old values and skip the spike stage
					cv <= eval && ok; // RULE19
					dist_err_o[c] <= eval && !ok;
					if (eval)
						last_ok <= ok;
					if (eval && ok)
					begin
						da <= ca;
						db <= cb;
					end
				end
			end

			wire [P_W-1:0] sa;
			wire [P_W-1:0] sb;
			wire rep_a;
			wire rep_b;
			wire [31:0] spk = cfg_spike[c];

			// same filter on both output distances, ahead of any averaging
			psf_spike #(.W(P_W), .DEPTH_MAX(10)) u_spike_a (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.en_i(ctl[`PSF_F_SPIKE]),
				.depth_i(spk[`PSF_F_DEPTH]),
				.tol_i(spk[`PSF_F_TOL]),
				.max_corr_i(spk[`PSF_F_MAXC]),
				.in_valid_i(cv),
				.in_data_i(da),
				.out_valid_o(dist_valid_o[c]),
				.out_data_o(sa),
				.replaced_o(rep_a)
			); // RULE17 RULE18
			psf_spike #(.W(P_W), .DEPTH_MAX(10)) u_spike_b (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.en_i(ctl[`PSF_F_SPIKE]),
				.depth_i(spk[`PSF_F_DEPTH]),
				.tol_i(spk[`PSF_F_TOL]),
				.max_corr_i(spk[`PSF_F_MAXC]),
				.in_valid_i(cv),
				.in_data_i(db),
				.out_valid_o(),
				.out_data_o(sb),
				.replaced_o(rep_b)
			); // RULE17

			assign dist_a_o[c*P_W +: P_W] = sa;
			assign dist_b_o[c*P_W +: P_W] = sb;
			assign dist_spike_o[c] = rep_a || rep_b;
			assign stat_w[c] = {27'h000_0000, last_ok, in_pk, npk};
			assign out0_w[c] = {{(32-P_W){1'b0}}, sa};
			assign out1_w[c] = {{(32-P_W){1'b0}}, sb};
		end
	endgenerate

endmodule // psf_top
`default_nettype wire

// File: testbench/psf_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module psf_top_asserts #(
	parameter D_W = 12,
	parameter P_W = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// stream
	input wire logic [1:0] vid_valid_i,
	input wire logic [1:0] vid_last_i,
	input wire logic [1:0] dist_valid_o,
	input wire logic [2*P_W-1:0] dist_a_o,
	input wire logic [1:0] dist_spike_o,
	input wire logic [1:0] dist_err_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_end;
		vid_valid_i[0] && vid_last_i[0];
	endsequence
	a_ack_next: assert property (s_req |=> wb_ack_o)
		else $error("ack missing");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
		else $error("ack without request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	a_frame_answer: assert property (
		s_end |-> ##2 ((dist_err_o[0] ##1 !dist_valid_o[0]) or (!dist_err_o[0] ##1 dist_valid_o[0])))
		else $error("frame answer wrong");
	a_valid_cause: assert property (dist_valid_o[0] |-> $past(vid_valid_i[0] && vid_last_i[0], 3))
		else $error("valid without frame");
	a_err_pulse: assert property (dist_err_o[0] |=> !dist_err_o[0])
		else $error("error too long");
	a_spike_flag: assert property (dist_spike_o[0] |-> dist_valid_o[0])
		else $error("spike flag alone");
	a_dist_hold: assert property (!dist_valid_o[0] |-> $stable(dist_a_o[P_W-1:0]))
		else $error("distance moved");
endmodule // psf_top_asserts

bind psf_top psf_top_asserts #(.D_W(D_W), .P_W(P_W)) psf_top_asserts_i (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .vid_valid_i(vid_valid_i),
	.vid_last_i(vid_last_i), .dist_valid_o(dist_valid_o), .dist_a_o(dist_a_o),
	.dist_spike_o(dist_spike_o), .dist_err_o(dist_err_o));
`default_nettype wire

// File: testbench/psf_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module psf_top_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, rd;
	wire [31:0] wb_dat_o, dist_a_o, dist_b_o;
	wire wb_ack_o;
	wire [1:0] vid_valid_i, vid_start_i, vid_last_i, dist_valid_o, dist_spike_o, dist_err_o;
	wire [23:0] vid_dark_i, vid_light_i;
	int fail_count = 0, samples_checked = 0, cycles = 0, i;
	logic [15:0] ra, rb;
	logic rsp, rerr;
	logic [15:0] ea [3] = '{16'h0004, 16'h000A, 16'h0014};
	logic [15:0] eb [3] = '{16'h000A, 16'h0014, 16'h0014};

	always #12.5 clk_i = ~clk_i;

	psf_top psf_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vid_valid_i(vid_valid_i),
		.vid_start_i(vid_start_i), .vid_last_i(vid_last_i), .vid_dark_i(vid_dark_i),
		.vid_light_i(vid_light_i), .dist_valid_o(dist_valid_o), .dist_a_o(dist_a_o),
		.dist_b_o(dist_b_o), .dist_spike_o(dist_spike_o), .dist_err_o(dist_err_o));
	psf_vid_src psf_vid_src_i (.clk_i(clk_i), .valid_o(vid_valid_i), .start_o(vid_start_i),
		.last_o(vid_last_i), .dark_o(vid_dark_i), .light_o(vid_light_i));

	task conclude;
		$display("checks %0d errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// classic single wishbone cycle, held until ack is sampled
	task wb(input logic [7:0] a, input logic we, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] exp);
		wb(a, 1'b0, 32'h0000_0000, 4'h0);
		check(rd, exp);
	endtask

	task frame(input int ch, input int n, input logic [55:0] pos, input logic [83:0] lit,
		input logic [11:0] dk);
		int k;
		psf_vid_src_i.send(ch, n, pos, lit, dk);
		for (k = 0; k < 40; k++)
		begin
			@(negedge clk_i);
			if (dist_valid_o[ch] === 1'b1 || dist_err_o[ch] === 1'b1)
				break;
		end
		if (k == 40)
			check(32'h0000_0000, 32'h0000_0001);
		{ra, rb, rsp, rerr} = {dist_a_o[ch*16+:16], dist_b_o[ch*16+:16], dist_spike_o[ch],
			dist_err_o[ch]};
	endtask

	function logic [31:0] ctrl(input logic two, input logic [1:0] sel, input logic refr,
		input logic spk, input logic [6:0] thr);
		return {10'h000, 1'b0, spk, refr, sel, two, 1'b0, 7'h32, 1'b0, thr};
	endfunction

	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 6000)
		begin
			fail_count++;
			conclude();
		end
	end

	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(8'h00, 32'h0008_3202);
		rchk(8'h20, 32'h0008_3202);
		rchk(8'h04, 32'h0000_1000);
		rchk(8'h08, 32'h1000_1000);
		rchk(8'h0C, 32'h0000_0001);
		rchk(8'h1C, 32'h0000_0000);
		rchk(8'h40, 32'h0000_0000);
		wb(8'h0C, 1'b1, 32'h0003_7F0F, 4'hF);
		rchk(8'h0C, 32'h0003_640A);
		wb(8'h0C, 1'b1, 32'h0000_0001, 4'hF);
		wb(8'h00, 1'b1, 32'hFFFF_FF05, 4'h1);
		rchk(8'h00, 32'h0008_3205);
		for (i = 0; i < 6; i++)
		begin
			wb(8'h00, 1'b1, ctrl(i > 2, 2'(i % 3), 1'b1, 1'b0, 7'h02), 4'hF);
			frame(0, 3, 56'h14_0A04, 84'h0_C812_C064, 12'h800);
			check(32'(ra), (i == 5) ? 32'h0000_000A : 32'(ea[i%3]));
			if (i > 2) check(32'(rb), 32'(eb[i%3]));
		end
		frame(0, 1, 56'h0A, 84'h100, 12'h800);
		check(32'(rerr), 32'h0000_0001);
		wb(8'h00, 1'b1, ctrl(1'b0, 2'h2, 1'b1, 1'b0, 7'h02), 4'hF);
		frame(0, 7, 56'h1A_1612_0E0A_0602, 84'h1_0010_0100_1001_0010_0100, 12'h800);
		check(32'(ra), 32'h0000_0016);
		wb(8'h00, 1'b1, ctrl(1'b0, 2'h0, 1'b1, 1'b0, 7'h32), 4'hF);
		frame(0, 2, 56'h0A04, 84'h10_0100, 12'h7F0);
		check(32'(rerr), 32'h0000_0001);
		frame(0, 2, 56'h0A04, 84'h10_0100, 12'h800);
		check(32'(ra), 32'h0000_0004);
		wb(8'h24, 1'b1, 32'h0000_2000, 4'hF);
		wb(8'h20, 1'b1, ctrl(1'b0, 2'h2, 1'b1, 1'b0, 7'h02), 4'hF);
		frame(1, 2, 56'h0A04, 84'h10_0100, 12'h800);
		check(32'(ra), 32'h0000_0010);
		wb(8'h00, 1'b1, ctrl(1'b0, 2'h2, 1'b1, 1'b0, 7'h02), 4'hF);
		frame(0, 2, 56'h0A04, 84'h10_0100, 12'h800);
		check(32'(ra), 32'h0000_000A);
		wb(8'h20, 1'b1, ctrl(1'b0, 2'h2, 1'b0, 1'b0, 7'h02), 4'hF);
		frame(1, 2, 56'h0A04, 84'h10_0100, 12'h800);
		check(32'(ra), 32'h0000_000A);
		wb(8'h34, 1'b1, 32'hFFFF_FFFF, 4'hF);
		rchk(8'h34, 32'h0000_000A);
		// three-index material mode uses the middle index
		wb(8'h28, 1'b1, 32'h0000_3000, 4'hF);
		wb(8'h20, 1'b1, ctrl(1'b0, 2'h2, 1'b1, 1'b0, 7'h02) | 32'h0020_0000, 4'hF);
		frame(1, 2, 56'h0A04, 84'h10_0100, 12'h800);
		check(32'(ra), 32'h0000_0016);
		// overlapping peaks on a raised floor: split at fifty, merged at ninety
		psf_vid_src_i.floor_lvl = 12'h100;
		wb(8'h20, 1'b1, ctrl(1'b1, 2'h0, 1'b0, 1'b0, 7'h02), 4'hF);
		frame(1, 2, 56'h0A04, 84'h10_0100, 12'h800);
		check(32'(ra), 32'h0000_0004);
		check(32'(rb), 32'h0000_000A);
		wb(8'h20, 1'b1, 32'h0000_5A00, 4'h2);
		frame(1, 2, 56'h0A04, 84'h10_0100, 12'h800);
		check(32'(rerr), 32'h0000_0001);
		psf_vid_src_i.floor_lvl = 12'h000;
		// spike run: history of 10s, then a jump to 30 three times
		wb(8'h00, 1'b1, ctrl(1'b0, 2'h0, 1'b1, 1'b0, 7'h02), 4'hF);
		frame(0, 1, 56'h0A, 84'h100, 12'h800);
		wb(8'h0C, 1'b1, 32'h0003_0202, 4'hF);
		wb(8'h00, 1'b1, ctrl(1'b0, 2'h0, 1'b1, 1'b1, 7'h02), 4'hF);
		for (i = 0; i < 3; i++)
		begin
			frame(0, 1, 56'h1E, 84'h100, 12'h800);
			check(32'(ra), (i < 2) ? 32'h0000_000A : 32'h0000_001E);
			check(32'(rsp), 32'(i < 2));
		end
		conclude();
	end
endmodule // psf_top_bench
`default_nettype wire

// File: testbench/psf_vid_src.sv
`timescale 1ns/1ps
`default_nettype none
module psf_vid_src #(
	parameter D_W = 12
) (
	// clock
	input wire logic clk_i,
	// video lanes
	output logic [1:0] valid_o,
	output logic [1:0] start_o,
	output logic [1:0] last_o,
	output logic [2*D_W-1:0] dark_o,
	output logic [2*D_W-1:0] light_o
);
	initial {valid_o, start_o, last_o, dark_o, light_o} = '0;
	// dark level between peaks; raised above threshold to make overlapping peaks
	logic [D_W-1:0] floor_lvl = '0;
	// one 32-sample frame, single-sample peaks at the given positions
	task automatic send(input int ch, input int n, input logic [55:0] pos,
		input logic [83:0] lit, input logic [D_W-1:0] dk);
		logic [D_W-1:0] dv;
		logic [D_W-1:0] lv;
		for (int s = 0; s < 32; s++)
		begin
			dv = floor_lvl;
			lv = dk >> 4;
			for (int k = 0; k < n; k++)
				if (pos[8*k+:8] == 8'(s)) {dv, lv} = {dk, lit[12*k+:12]};
			@(posedge clk_i);
			valid_o <= 2'b01 << ch;
			start_o <= (s == 0) ? 2'b01 << ch : 2'b00;
			last_o <= (s == 31) ? 2'b01 << ch : 2'b00;
			// idle lane carries the inverse of the active lane's sample
			dark_o <= ch ? {dv, ~dv} : {~dv, dv};
			light_o <= ch ? {lv, ~lv} : {~lv, lv};
		end
		@(posedge clk_i);
		{valid_o, start_o, last_o} <= '0;
		dark_o <= ~dark_o;
		light_o <= ~light_o;
	endtask
endmodule // psf_vid_src
`default_nettype wire
